// ---- src/sps_pkg.sv ----
// Purpose: Shared constants and helpers for the serial port status block
// Assumes: 8-bit register port, word index addressing
// Notes:   Offsets below are word indices on the plain register port
package sps_pkg;

   // Register port widths
   localparam int unsigned SPS_AW = 4;
   localparam int unsigned SPS_DW = 8;

   // Register offsets
   localparam logic [SPS_AW-1:0] SPS_OFF_STATUS = 4'h0;
   localparam logic [SPS_AW-1:0] SPS_OFF_EVENT  = 4'h1;
   localparam logic [SPS_AW-1:0] SPS_OFF_MASK   = 4'h2;
   localparam logic [SPS_AW-1:0] SPS_OFF_STATE  = 4'h3;

   // Status register fields
   localparam int unsigned SPS_BIT_SMP   = 7;
   localparam int unsigned SPS_BIT_CKE   = 6;
   localparam int unsigned SPS_BIT_DNA   = 5;
   localparam int unsigned SPS_BIT_STOP  = 4;
   localparam int unsigned SPS_BIT_START = 3;
   localparam int unsigned SPS_BIT_RNW   = 2;
   localparam int unsigned SPS_BIT_UA    = 1;
   localparam int unsigned SPS_BIT_BF    = 0;

   localparam logic [SPS_DW-1:0] SPS_STATUS_RST = 8'h00;
   localparam logic [SPS_DW-1:0] SPS_ZERO       = 8'h00;

   // Event bits for the interrupt status and mask registers
   localparam int unsigned SPS_NEV      = 4;
   localparam int unsigned SPS_EV_START = 0;
   localparam int unsigned SPS_EV_STOP  = 1;
   localparam int unsigned SPS_EV_BF    = 2;
   localparam int unsigned SPS_EV_UA    = 3;
   localparam logic [SPS_NEV-1:0] SPS_EV_RST = 4'h0;

   // Idle level of the bus lines
   localparam logic SPS_LINE_IDLE = 1'b1;

   typedef enum logic [0:0] {
      SPS_BUS_IDLE,
      SPS_BUS_BUSY
   } sps_bus_e;

   // Sticky flag update; a set in the clearing cycle wins
   function automatic logic sps_set_clr(input logic cur, input logic set, input logic clr);
      sps_set_clr = set | (cur & ~clr);
   endfunction

endpackage

// ---- src/sps_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clock_i
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module sps_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic resetn_i,
   // Raw and filtered level
   input  wire logic async_i,
   output logic      level_o
);
   import sps_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sps_sync_s;

   sps_sync_s st_q;
   sps_sync_s st_d;

   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // First stage feeds only the second
      if (st_q.s2 == st_q.s3)
      begin
         st_d.lvl = st_q.s3;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign level_o = st_q.lvl;

endmodule

// ---- src/sps_irq.sv ----
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Event pulses are on clock_i
// Notes:   Write one to clear; a new event beats a clear
`timescale 1ns/1ps
module sps_irq #(
   parameter int unsigned N = 4
) (
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         resetn_i,
   // Events
   input  wire logic [N-1:0] event_i,
   // Software access
   input  wire logic         wr_stat_i,
   input  wire logic         wr_mask_i,
   input  wire logic [N-1:0] wdata_i,
   // State
   output logic      [N-1:0] stat_o,
   output logic      [N-1:0] mask_o,
   output logic              irq_o
);
   import sps_pkg::*;

   typedef struct packed {
      logic [N-1:0] stat;
      logic [N-1:0] mask;
      logic         irq;
   } sps_irq_s;

   sps_irq_s st_q;
   sps_irq_s st_d;

   always_comb
   begin
      st_d = st_q;
      for (int i = 0; i < N; i++)
      begin
         st_d.stat[i] = sps_set_clr(st_q.stat[i], event_i[i], wr_stat_i & wdata_i[i]);
      end
      if (wr_mask_i)
      begin
         st_d.mask = wdata_i;
      end
      st_d.irq = |(st_d.stat & st_d.mask);
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign stat_o = st_q.stat;
   assign mask_o = st_q.mask;
   assign irq_o  = st_q.irq;

endmodule

// ---- src/sps_top.sv ----
// Purpose: Status and sampling control register of a combined SPI/I2C port
// Assumes: Engine events arrive on clock_i; bus lines are raw pins
// Notes:   Start and Stop are detected here from the synchronised lines
//
// Contract
// R1 - SPI master samples at end when set
// R2 - Software keeps sample phase clear as slave
// R3 - I2C: sample phase set disables slew control
// R4 - SPI: edge select picks transmit clock edge
// R5 - I2C: edge select enables SMBus thresholds
// R6 - Last I2C byte data sets, address clears
// R7 - Stop flag tracks last condition, cleared disabled
// R8 - Start flag tracks last condition, cleared disabled
// R9 - Slave latches read/write bit on match
// R10 - Slave direction valid until Start/Stop/NACK
// R11 - Master direction shows transmit; OR gives idle
// R12 - Ten-bit mode flags address reload needed
// R13 - Receive complete sets buffer full
// R14 - I2C transmit holds buffer full until done
// R15 - Only the two control bits are writable
`timescale 1ns/1ps
module sps_top (
   // Clock and reset
   input  wire logic                       clock_i,
   input  wire logic                       resetn_i,
   // Register port
   input  wire logic [sps_pkg::SPS_AW-1:0] addr_i,
   input  wire logic [sps_pkg::SPS_DW-1:0] wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [sps_pkg::SPS_DW-1:0] rdata_o,
   // Port configuration
   input  wire logic                       port_enable_i,
   input  wire logic                       i2c_mode_i,
   input  wire logic                       master_i,
   input  wire logic                       ten_bit_i,
   // Bus lines
   input  wire logic                       scl_i,
   input  wire logic                       sda_i,
   // Byte engine events
   input  wire logic                       byte_done_i,
   input  wire logic                       byte_is_data_i,
   input  wire logic                       addr_match_i,
   input  wire logic                       rw_bit_i,
   input  wire logic                       nack_i,
   input  wire logic                       tx_busy_i,
   input  wire logic                       seq_req_i,
   input  wire logic                       ua_req_i,
   input  wire logic                       own_addr_wr_i,
   input  wire logic                       rx_complete_i,
   input  wire logic                       buf_read_i,
   input  wire logic                       tx_load_i,
   input  wire logic                       tx_done_i,
   // Engine controls
   output logic                            sample_at_end_o,
   output logic                            tx_active_idle_o,
   output logic                            slew_ctrl_en_o,
   output logic                            smbus_thresh_o,
   output logic                            port_idle_o,
   output logic                            rnw_valid_o,
   output logic                            bus_busy_o,
   // Status and interrupt
   output logic      [sps_pkg::SPS_DW-1:0] status_o,
   output logic                            irq_o
);
   import sps_pkg::*;

   typedef struct packed {
      logic            input_sample_phase;
      logic            cke;
      logic            dna;
      logic            stop;
      logic            start;
      logic            rnw_slv;
      logic            rnw_vld;
      logic            ua;
      logic            bf;
      sps_bus_e        bus;
      logic            scl_p;
      logic            sda_p;
      logic [SPS_DW-1:0] rdata;
      logic [SPS_DW-1:0] status;
      logic            sample_end;
      logic            tx_ai;
      logic            slew;
      logic            smb;
      logic            idle;
      logic            vld;
      logic            busy;
      logic            irq;
   } sps_top_s;

   sps_top_s st_q;
   sps_top_s st_d;

   // One packing for reads and for the status copy
   function automatic logic [SPS_DW-1:0] status_image(input sps_top_s s, input logic rnw);
      logic [SPS_DW-1:0] img;
      img                = SPS_ZERO;
      img[SPS_BIT_SMP]   = s.input_sample_phase;
      img[SPS_BIT_CKE]   = s.cke;
      img[SPS_BIT_DNA]   = s.dna;
      img[SPS_BIT_STOP]  = s.stop;
      img[SPS_BIT_START] = s.start;
      img[SPS_BIT_RNW]   = rnw;
      img[SPS_BIT_UA]    = s.ua;
      img[SPS_BIT_BF]    = s.bf;
      return img;
   endfunction

   logic              scl_s;
   logic              sda_s;
   logic              start_det;
   logic              stop_det;
   logic              wr_status;
   logic              wr_event;
   logic              wr_mask;
   logic              rnw_live;
   logic              bf_set;
   logic              bf_clr;
   logic              ua_set;
   logic [SPS_NEV-1:0] events;
   logic [SPS_NEV-1:0] ev_stat;
   logic [SPS_NEV-1:0] ev_mask;
   logic              irq_lvl;
   logic [SPS_DW-1:0] status_view;
   logic [SPS_DW-1:0] state_view;

   // Bus lines come from pins
   sps_sync #(
      .RST_VAL (SPS_LINE_IDLE)
   ) u_scl_sync (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .async_i  (scl_i),
      .level_o  (scl_s)
   );

   sps_sync #(
      .RST_VAL (SPS_LINE_IDLE)
   ) u_sda_sync (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .async_i  (sda_i),
      .level_o  (sda_s)
   );

   // Conditions: data moves while clock is high
   always_comb
   begin
      start_det = i2c_mode_i & port_enable_i & scl_s & st_q.scl_p & st_q.sda_p & ~sda_s;
      stop_det  = i2c_mode_i & port_enable_i & scl_s & st_q.scl_p & ~st_q.sda_p & sda_s;
   end

   // Write decode
   always_comb
   begin
      wr_status = wr_i & (addr_i == SPS_OFF_STATUS);
      wr_event  = wr_i & (addr_i == SPS_OFF_EVENT);
      wr_mask   = wr_i & (addr_i == SPS_OFF_MASK);
   end

   // Buffer full set and clear terms
   always_comb
   begin
      bf_set = rx_complete_i | (i2c_mode_i & tx_load_i); // R13 R14
      bf_clr = buf_read_i | (i2c_mode_i & tx_done_i); // R13 R14
      ua_set = i2c_mode_i & ten_bit_i & ua_req_i; // R12
   end

   // Direction bit depends on role
   always_comb
   begin
      if (master_i)
      begin
         rnw_live = tx_busy_i; // R11
      end
      else
      begin
         rnw_live = st_q.rnw_slv; // R9
      end
   end

   always_comb
   begin
      events               = '0;
      events[SPS_EV_START] = start_det;
      events[SPS_EV_STOP]  = stop_det;
      events[SPS_EV_BF]    = bf_set;
      events[SPS_EV_UA]    = ua_set;
   end

   sps_irq #(
      .N (SPS_NEV)
   ) u_irq (
      .clock_i   (clock_i),
      .resetn_i  (resetn_i),
      .event_i   (events),
      .wr_stat_i (wr_event),
      .wr_mask_i (wr_mask),
      .wdata_i   (wdata_i[SPS_NEV-1:0]),
      .stat_o    (ev_stat),
      .mask_o    (ev_mask),
      .irq_o     (irq_lvl)
   );

   // Register image as software sees it
   always_comb
   begin
      status_view                = status_image(st_q, i2c_mode_i & rnw_live);
      state_view                 = SPS_ZERO;
      state_view[0]              = port_enable_i;
      state_view[1]              = i2c_mode_i;
      state_view[2]              = master_i;
      state_view[3]              = st_q.rnw_vld;
      state_view[4]              = (st_q.bus == SPS_BUS_BUSY);
   end

   always_comb
   begin
      st_d       = st_q;
      st_d.scl_p = scl_s;
      st_d.sda_p = sda_s;

      // Writes reach only the two control bits
      if (wr_status)
      begin
         st_d.input_sample_phase = wdata_i[SPS_BIT_SMP]; // R15
         st_d.cke = wdata_i[SPS_BIT_CKE]; // R15
      end

      // Last byte kind
      if (i2c_mode_i && byte_done_i)
      begin
         st_d.dna = byte_is_data_i; // R6
      end

      // Last detected condition; disabling clears both
      if (!port_enable_i)
      begin
         st_d.start = 1'b0; // R7 R8
         st_d.stop  = 1'b0; // R7 R8
      end
      else if (start_det)
      begin
         st_d.start = 1'b1; // R8
         st_d.stop  = 1'b0; // R7
      end
      else if (stop_det)
      begin
         st_d.stop  = 1'b1; // R7
         st_d.start = 1'b0; // R8
      end

      // Bus occupancy between conditions
      case (st_q.bus)
         SPS_BUS_IDLE:
         begin
            if (start_det)
            begin
               st_d.bus = SPS_BUS_BUSY;
            end
         end
         SPS_BUS_BUSY:
         begin
            if (stop_det || !port_enable_i)
            begin
               st_d.bus = SPS_BUS_IDLE;
            end
         end
         default:
         begin
            st_d.bus = SPS_BUS_IDLE;
         end
      endcase

      // Slave direction latch and its validity window
      if (i2c_mode_i && !master_i && addr_match_i)
      begin
         st_d.rnw_slv = rw_bit_i; // R9
         st_d.rnw_vld = 1'b1; // R10
      end
      else if (start_det || stop_det || nack_i || !port_enable_i)
      begin
         st_d.rnw_vld = 1'b0; // R10
      end

      // Address reload request; reload in the same cycle loses
      st_d.ua = sps_set_clr(st_q.ua, ua_set, own_addr_wr_i); // R12

      // Buffer full; a new fill beats a drain
      st_d.bf = sps_set_clr(st_q.bf, bf_set, bf_clr); // R13 R14

      // Read data valid only the cycle after the strobe
      st_d.rdata = SPS_ZERO;
      if (rd_i)
      begin
         case (addr_i)
            SPS_OFF_STATUS: st_d.rdata = status_view;
            SPS_OFF_EVENT:  st_d.rdata = {{(SPS_DW-SPS_NEV){1'b0}}, ev_stat};
            SPS_OFF_MASK:   st_d.rdata = {{(SPS_DW-SPS_NEV){1'b0}}, ev_mask};
            SPS_OFF_STATE:  st_d.rdata = state_view;
            default:        st_d.rdata = SPS_ZERO;
         endcase
      end

      // Registered engine controls
      // Copy built from next state, so it lags one edge like the controls
      st_d.status     = status_image(st_d, i2c_mode_i & (master_i ? tx_busy_i : st_d.rnw_slv)); // R9 R11
      st_d.sample_end = ~i2c_mode_i & master_i & st_d.input_sample_phase; // R1
      st_d.tx_ai      = ~i2c_mode_i & st_d.cke; // R4
      st_d.slew       = i2c_mode_i & ~st_d.input_sample_phase; // R3
      st_d.smb        = i2c_mode_i & st_d.cke; // R5
      st_d.idle       = ~(rnw_live | seq_req_i); // R11
      st_d.vld        = st_d.rnw_vld;
      st_d.busy       = (st_d.bus == SPS_BUS_BUSY);
      st_d.irq        = irq_lvl;
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         st_q        <= '0;
         st_q.bus    <= SPS_BUS_IDLE;
         st_q.scl_p  <= SPS_LINE_IDLE;
         st_q.sda_p  <= SPS_LINE_IDLE;
         st_q.status <= SPS_STATUS_RST;
         st_q.idle   <= 1'b1;
         st_q.slew   <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign rdata_o          = st_q.rdata;
   assign sample_at_end_o  = st_q.sample_end;
   assign tx_active_idle_o = st_q.tx_ai;
   assign slew_ctrl_en_o   = st_q.slew;
   assign smbus_thresh_o   = st_q.smb;
   assign port_idle_o      = st_q.idle;
   assign rnw_valid_o      = st_q.vld;
   assign bus_busy_o       = st_q.busy;
   assign status_o         = st_q.status;
   assign irq_o            = st_q.irq;

endmodule

// ---- bench/sps_peer.sv ----
// Purpose: I2C peer that makes Start and Stop on the bus lines
// Assumes: Lines have pull-ups, so they idle high
// Notes:   Each level holds six clocks, well past the input filter
`timescale 1ns/1ps
module sps_peer (
   // Clock
   input  wire logic clock_i,
   // Bus lines
   output logic      scl_o,
   output logic      sda_o
);
   initial
   begin
      scl_o = 1'h1;
      sda_o = 1'h1;
   end
   // Data moves with the clock low, so only the final edge counts
   task automatic cond(input logic s);
      @(posedge clock_i);
      scl_o <= 1'h0;
      sda_o <= ~s;
      repeat (6) @(posedge clock_i);
      scl_o <= 1'h1;
      repeat (6) @(posedge clock_i);
      sda_o <= s;
      repeat (6) @(posedge clock_i);
   endtask
endmodule

// ---- bench/sps_top_chk.sv ----
// Purpose: Port assertions for the status block
// Assumes: Registered outputs lag their causes by one edge
// Notes:   Status copy shares the one-edge lag, so bits compare directly
`timescale 1ns/1ps
module sps_top_chk (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Inputs
   input wire logic port_enable_i,
   input wire logic i2c_mode_i,
   input wire logic master_i,
   input wire logic tx_busy_i,
   input wire logic seq_req_i,
   input wire logic nack_i,
   input wire logic addr_match_i,
   input wire logic rx_complete_i,
   // Outputs
   input wire logic sample_at_end_o,
   input wire logic tx_active_idle_o,
   input wire logic slew_ctrl_en_o,
   input wire logic smbus_thresh_o,
   input wire logic port_idle_o,
   input wire logic rnw_valid_o,
   input wire logic bus_busy_o,
   input wire logic [sps_pkg::SPS_DW-1:0] status_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   a_spi_sample: assert property ($past(resetn_i && !i2c_mode_i && master_i)
      |-> sample_at_end_o == status_o[7]) else $error("sample point differs from control bit");
   a_slew_ctrl: assert property ($past(resetn_i && i2c_mode_i)
      |-> slew_ctrl_en_o == !status_o[7]) else $error("slew control differs from control bit");
   a_edge_sel: assert property ($past(resetn_i && !i2c_mode_i)
      |-> tx_active_idle_o == status_o[6]) else $error("transmit edge differs from control bit");
   a_smbus_thr: assert property ($past(resetn_i && i2c_mode_i)
      |-> smbus_thresh_o == status_o[6]) else $error("threshold select differs from control bit");
   a_flags_off: assert property (!port_enable_i [*3]
      |-> !status_o[4] && !status_o[3]) else $error("condition flag kept while disabled");
   a_start_excl: assert property (status_o[3] |-> !status_o[4])
      else $error("start and stop flags set together");
   a_busy_start: assert property ($rose(bus_busy_o) |-> ##[0:1] status_o[3])
      else $error("bus busy without start flag");
   a_idle_busy: assert property ($past(resetn_i && i2c_mode_i && master_i && (tx_busy_i || seq_req_i))
      |-> !port_idle_o) else $error("idle shown during transmit or request");
   a_rnw_drop: assert property (nack_i && !addr_match_i |-> ##[1:2] !rnw_valid_o)
      else $error("direction still valid after nack");
   a_bf_set: assert property (rx_complete_i |-> ##[1:2] status_o[0])
      else $error("buffer full not set after receive");
endmodule

bind sps_top sps_top_chk u_chk (.*);

// ---- bench/test_serial_port_status.sv ----
// Purpose: Self-checking bench for the status block
// Assumes: Peer makes bus conditions; bench plays the byte engine
// Notes:   Seed 66 keeps random data and direction repeatable
`timescale 1ns/1ps
module test_serial_port_status;
   import sps_pkg::*;
   logic              clock_i = 0;
   logic              resetn_i = 0;
   logic [SPS_AW-1:0] addr_i = 0;
   logic [SPS_DW-1:0] wdata_i = 0;
   logic [SPS_DW-1:0] rdata_o;
   logic [SPS_DW-1:0] status_o;
   logic              wr_i = 0, rd_i = 0, en = 1, i2c = 1, mst = 0, ten = 1;
   logic              dat = 0, rwb = 0, txb = 0, seq = 0, d = 0, r = 0;
   logic [8:0]        ev = 0;
   logic              sae, tai, slew, smb, idle, rnwv, busy, irq, scl, sda;
   int                error_cnt = 0, check_count = 0, cyc = 0, seed = 66;
   // Which output a delayed flag check looks at
   localparam int     F_BUSY = 0, F_IRQ = 1, F_RNWV = 2, F_IDLE = 3;
   // Mode, master, control write, expected sample/edge/slew/thresh
   logic [13:0]       tb [6] = '{14'h2FF1, 14'h2002, 14'h1FFC, 14'h1404, 14'h1808, 14'h0000};

   always #20 clock_i = ~clock_i;

   sps_peer peer (.clock_i(clock_i), .scl_o(scl), .sda_o(sda));
   sps_top dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_enable_i(en), .i2c_mode_i(i2c),
      .master_i(mst), .ten_bit_i(ten), .scl_i(scl), .sda_i(sda), .byte_done_i(ev[0]),
      .byte_is_data_i(dat), .addr_match_i(ev[1]), .rw_bit_i(rwb), .nack_i(ev[2]), .tx_busy_i(txb),
      .seq_req_i(seq), .ua_req_i(ev[3]), .own_addr_wr_i(ev[4]), .rx_complete_i(ev[5]),
      .buf_read_i(ev[6]), .tx_load_i(ev[7]), .tx_done_i(ev[8]), .sample_at_end_o(sae),
      .tx_active_idle_o(tai), .slew_ctrl_en_o(slew), .smbus_thresh_o(smb), .port_idle_o(idle),
      .rnw_valid_o(rnwv), .bus_busy_o(busy), .status_o(status_o), .irq_o(irq));

   // Bit 2 follows transmit as master, latched direction as slave
   function automatic logic [7:0] st(input logic p, s, u, b);
      return {2'h0, d, p, s, i2c & (mst ? txb : r), u, b};
   endfunction

   task automatic chk(input logic [7:0] g, e);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   // Output picked after the wait, so the value is current, not the one at the call
   task automatic flag(input int s, input logic e);
      logic g;
      repeat (2) @(posedge clock_i);
      #1 g = (s == F_BUSY) ? busy : (s == F_IRQ) ? irq : (s == F_RNWV) ? rnwv : idle;
      chk({7'h0, g}, {7'h0, e});
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock_i);
      wr_i <= 1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clock_i);
      wr_i <= 0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock_i);
      rd_i <= 1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 0;
      #1 chk(rdata_o, e);
   endtask

   task automatic pulse(input logic [8:0] m);
      @(posedge clock_i);
      ev <= m;
      @(posedge clock_i);
      ev <= 0;
      repeat (3) @(posedge clock_i);
   endtask

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (16) @(posedge clock_i);
      resetn_i <= 1;
      rd(SPS_OFF_STATUS, SPS_STATUS_RST);
      rd(SPS_OFF_EVENT, 8'h00);
      rd(SPS_OFF_MASK, 8'h00);
      rd(SPS_OFF_STATE, 8'h03);
      rd(4'hF, 8'h00);
      $display("Test reset done");
      foreach (tb[i])
      begin
         @(posedge clock_i);
         i2c <= tb[i][13];
         mst <= tb[i][12];
         wr(SPS_OFF_STATUS, tb[i][11:4]);
         rd(SPS_OFF_STATUS, tb[i][11:4] & 8'hC0);
         flag(F_IRQ, 1'h0);
         #1 chk({4'h0, sae, tai, slew, smb}, {4'h0, tb[i][3:0]});
         chk(status_o, tb[i][11:4] & 8'hC0);
      end
      @(posedge clock_i);
      i2c <= 1;
      mst <= 0;
      $display("Test control done");
      peer.cond(0);
      rd(SPS_OFF_STATUS, st(0, 1, 0, 0));
      flag(F_BUSY, 1);
      rd(SPS_OFF_EVENT, 8'h01);
      flag(F_IRQ, 0);
      wr(SPS_OFF_MASK, 8'h0F);
      flag(F_IRQ, 1);
      wr(SPS_OFF_EVENT, 8'h0F);
      flag(F_IRQ, 0);
      peer.cond(1);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      flag(F_BUSY, 0);
      flag(F_IRQ, 1);
      peer.cond(0);
      @(posedge clock_i);
      en <= 0;
      rd(SPS_OFF_STATUS, st(0, 0, 0, 0));
      @(posedge clock_i);
      en <= 1;
      peer.cond(1);
      wr(SPS_OFF_EVENT, 8'h0F);
      $display("Test conditions done");
      repeat (6)
      begin
         d = $random(seed);
         @(posedge clock_i);
         dat <= d;
         pulse(9'h001);
         rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      end
      repeat (4)
      begin
         r = $random(seed);
         @(posedge clock_i);
         rwb <= r;
         pulse(9'h002);
         flag(F_RNWV, 1);
         rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
         pulse(9'h004);
         flag(F_RNWV, 0);
      end
      $display("Test direction done");
      @(posedge clock_i);
      mst <= 1;
      txb <= 1;
      flag(F_IDLE, 0);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      @(posedge clock_i);
      txb <= 0;
      seq <= 1;
      flag(F_IDLE, 0);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      @(posedge clock_i);
      seq <= 0;
      flag(F_IDLE, 1);
      @(posedge clock_i);
      mst <= 0;
      pulse(9'h008);
      rd(SPS_OFF_STATUS, st(1, 0, 1, 0));
      pulse(9'h010);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      @(posedge clock_i);
      ten <= 0;
      pulse(9'h008);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      pulse(9'h060);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 1));
      pulse(9'h040);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      pulse(9'h080);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 1));
      pulse(9'h100);
      rd(SPS_OFF_STATUS, st(1, 0, 0, 0));
      rd(SPS_OFF_EVENT, 8'h0C);
      wr(SPS_OFF_EVENT, 8'h0C);
      flag(F_IRQ, 0);
      $display("Test flags done");
      report_and_stop();
   end
endmodule
